// file: rtl/iep_prio_enc.sv
// priority pick among eligible interrupt requests
`timescale 1ns/10ps
`default_nettype none
`include "iep_defs.svh"

module iep_prio_enc (
    input wire logic [6:0] req_in,
    input wire logic [20:0] prio_in,
    output logic valid_out,
    output logic [2:0] prio_out,
    output logic [2:0] src_out
);
    logic [2:0] best_p [0:7];
    logic [2:0] best_s [0:7];

    assign best_p[0] = 3'h0;
    assign best_s[0] = 3'h0;

    // strict compare: on equal priority the lower source number keeps the win
    genvar i;
    generate
        for (i = 0; i < `IEP_NSRC; i = i + 1) begin : g_chain
            logic take;
            assign take = req_in[i] && (prio_in[3*i +: 3] > best_p[i]);
            assign best_p[i+1] = take ? prio_in[3*i +: 3] : best_p[i];
            assign best_s[i+1] = take ? 3'(i) : best_s[i];
        end
    endgenerate

    assign valid_out = (best_p[7] != 3'h0);
    assign prio_out = best_p[7];
    assign src_out = best_s[7];
endmodule
`default_nettype wire

// file: rtl/iep_top.sv
// interrupt enable and priority slice with avalon-mm register access
// What this block does
// - an enable bit at one passes its source's request on, at zero it blocks it.
// - the capture channel seven enable sits at bit 6 and external interrupt one at bit 4.
// - the change notification enable sits at bit 3 and the comparator enable at bit 2.
// - the i2c master event enable sits at bit 1 and the i2c slave event enable at bit 0.
// - bit 5 of the enable register reads as zero and ignores writes.
// - the rtc priority is three bits at 10 to 8, seven highest, one lowest, zero disables.
`timescale 1ns/10ps
`default_nettype none
`include "iep_defs.svh"

module iep_top (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic [6:0] flags_in,
    output logic req_valid_out,
    output logic [2:0] req_priority_out,
    output logic [2:0] req_source_out,
    output logic irq_out
);
    localparam iep_pkg::iep_state_s RST_STATE = '{
        bus: iep_pkg::BUS_IDLE,
        waitreq: 1'b1,
        rdata: 32'h0,
        en_ic7: `IEP_RST_EN,
        en_int1: `IEP_RST_EN,
        en_cn: `IEP_RST_EN,
        en_cmp: `IEP_RST_EN,
        en_mi2c: `IEP_RST_EN,
        en_si2c: `IEP_RST_EN,
        rtc_en: `IEP_RST_EN,
        rtc_prio: `IEP_RST_RTC_PRIO,
        src_prio: `IEP_RST_SRC_PRIO,
        status: `IEP_RST_STATUS,
        mask: `IEP_RST_MASK,
        flags_q: 7'h0,
        req_valid: 1'b0,
        req_prio: 3'h0,
        req_src: 3'h0,
        irq: 1'b0
    };

    iep_pkg::iep_state_s s;
    iep_pkg::iep_state_s next_s;

    logic [6:0] en_vec;
    logic [20:0] prio_vec;
    logic [6:0] prio_nz;
    logic [6:0] elig;
    logic [6:0] rise;
    logic [6:0] clr;
    logic [31:0] rd_mux;
    logic commit_wr;
    logic enc_valid;
    logic [2:0] enc_prio;
    logic [2:0] enc_src;

    // per-source enable vector, indexed by source number
    always_comb begin
        en_vec = 7'h0;
        en_vec[`IEP_SRC_SI2C] = s.en_si2c;
        en_vec[`IEP_SRC_MI2C] = s.en_mi2c;
        en_vec[`IEP_SRC_CMP] = s.en_cmp;
        en_vec[`IEP_SRC_CN] = s.en_cn;
        en_vec[`IEP_SRC_INT1] = s.en_int1;
        en_vec[`IEP_SRC_IC7] = s.en_ic7;
        en_vec[`IEP_SRC_RTC] = s.rtc_en;
    end

    assign prio_vec = {s.rtc_prio, s.src_prio};

    // a zero priority code takes the source out of arbitration
    genvar k;
    generate
        for (k = 0; k < `IEP_NSRC; k = k + 1) begin : g_nz
            assign prio_nz[k] = (prio_vec[3*k +: 3] != 3'h0);
        end
    endgenerate

    // a source reaches the encoder only while its flag, its enable and a nonzero priority are all set
    assign elig = flags_in & en_vec & prio_nz;

    iep_prio_enc u_enc (
        .req_in(elig),
        .prio_in(prio_vec),
        .valid_out(enc_valid),
        .prio_out(enc_prio),
        .src_out(enc_src)
    );

    // writes land only on the edge where the master sees waitrequest low
    assign commit_wr = avs_write_in && !s.waitreq && (s.bus == iep_pkg::BUS_ACK);

    assign rise = flags_in & ~s.flags_q;
    assign clr = (commit_wr && avs_address_in == `IEP_OFS_STATUS && avs_byteenable_in[0])
        ? avs_writedata_in[6:0] : 7'h0;

    // read mux: unmapped offsets and unimplemented bits read as zero
    always_comb begin
        rd_mux = 32'h0;
        case (avs_address_in)
            `IEP_OFS_ENABLE: begin
                rd_mux[`IEP_BIT_IC7] = s.en_ic7;
                rd_mux[`IEP_BIT_INT1] = s.en_int1;
                rd_mux[`IEP_BIT_CN] = s.en_cn;
                rd_mux[`IEP_BIT_CMP] = s.en_cmp;
                rd_mux[`IEP_BIT_MI2C] = s.en_mi2c;
                rd_mux[`IEP_BIT_SI2C] = s.en_si2c;
                rd_mux[`IEP_BIT_RSVD] = 1'b0;
            end
            `IEP_OFS_PRIO: begin
                rd_mux[`IEP_BIT_RTC_PRIO_HI:`IEP_BIT_RTC_PRIO_LO] = s.rtc_prio;
            end
            `IEP_OFS_STATUS: begin
                rd_mux[6:0] = s.status;
            end
            `IEP_OFS_MASK: begin
                rd_mux[6:0] = s.mask;
            end
            `IEP_OFS_SRCPRIO: begin
                rd_mux[17:0] = s.src_prio;
            end
            `IEP_OFS_RTCCTL: begin
                rd_mux[`IEP_BIT_RTC_EN] = s.rtc_en;
            end
            default: begin
                rd_mux = 32'h0;
            end
        endcase
    end

    always_comb begin
        next_s = s;
        next_s.flags_q = flags_in;

        // bus handshake: one wait cycle, then a single cycle with waitrequest low
        case (s.bus)
            iep_pkg::BUS_IDLE: begin
                next_s.waitreq = 1'b1;
                if (avs_read_in || avs_write_in) begin
                    next_s.bus = iep_pkg::BUS_ACK;
                    next_s.waitreq = 1'b0;
                    next_s.rdata = avs_read_in ? rd_mux : 32'h0;
                end
            end
            iep_pkg::BUS_ACK: begin
                next_s.bus = iep_pkg::BUS_IDLE;
                next_s.waitreq = 1'b1;
            end
            default: begin
                next_s.bus = iep_pkg::BUS_IDLE;
                next_s.waitreq = 1'b1;
            end
        endcase

        if (commit_wr) begin
            case (avs_address_in)
                `IEP_OFS_ENABLE: begin
                    // bit 5 has no storage, so a write there simply falls away
                    if (avs_byteenable_in[0]) begin
                        next_s.en_ic7 = avs_writedata_in[`IEP_BIT_IC7];
                        next_s.en_int1 = avs_writedata_in[`IEP_BIT_INT1];
                        next_s.en_cn = avs_writedata_in[`IEP_BIT_CN];
                        next_s.en_cmp = avs_writedata_in[`IEP_BIT_CMP];
                        next_s.en_mi2c = avs_writedata_in[`IEP_BIT_MI2C];
                        next_s.en_si2c = avs_writedata_in[`IEP_BIT_SI2C];
                    end
                end
                `IEP_OFS_PRIO: begin
                    if (avs_byteenable_in[1]) begin
                        next_s.rtc_prio =
                            avs_writedata_in[`IEP_BIT_RTC_PRIO_HI:`IEP_BIT_RTC_PRIO_LO];
                    end
                end
                `IEP_OFS_MASK: begin
                    if (avs_byteenable_in[0]) begin
                        next_s.mask = avs_writedata_in[6:0];
                    end
                end
                `IEP_OFS_SRCPRIO: begin
                    if (avs_byteenable_in[0]) begin
                        next_s.src_prio[7:0] = avs_writedata_in[7:0];
                    end
                    if (avs_byteenable_in[1]) begin
                        next_s.src_prio[15:8] = avs_writedata_in[15:8];
                    end
                    if (avs_byteenable_in[2]) begin
                        next_s.src_prio[17:16] = avs_writedata_in[17:16];
                    end
                end
                `IEP_OFS_RTCCTL: begin
                    if (avs_byteenable_in[0]) begin
                        next_s.rtc_en = avs_writedata_in[`IEP_BIT_RTC_EN];
                    end
                end
                default: begin
                    next_s.rtc_en = s.rtc_en;
                end
            endcase
        end

        // a flag edge in the same cycle as its clear keeps the bit set
        next_s.status = (s.status & ~clr) | rise;
        next_s.irq = |(next_s.status & next_s.mask);

        next_s.req_valid = enc_valid;
        next_s.req_prio = enc_prio;
        next_s.req_src = enc_src;
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            s <= RST_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign avs_readdata_out = s.rdata;
    assign avs_waitrequest_out = s.waitreq;
    assign req_valid_out = s.req_valid;
    assign req_priority_out = s.req_prio;
    assign req_source_out = s.req_src;
    assign irq_out = s.irq;

    bus_ack_bound_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        ((avs_read_in || avs_write_in) && avs_waitrequest_out) |-> ##[1:2] !avs_waitrequest_out)
        else $error("bus request not answered in two cycles");

    enable_pass_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        (|elig) |=> req_valid_out)
        else $error("enabled request with priority did not reach the core");

    enable_block_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        !(|(flags_in & en_vec & prio_nz)) |=> !req_valid_out)
        else $error("request presented without enable and priority");

    ic7_int1_pos_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        (commit_wr && avs_address_in == `IEP_OFS_ENABLE && avs_byteenable_in[0]) |=>
        (s.en_ic7 == $past(avs_writedata_in[6]) && s.en_int1 == $past(avs_writedata_in[4])))
        else $error("capture or external enable not at its bit");

    cn_cmp_pos_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        (commit_wr && avs_address_in == `IEP_OFS_ENABLE && avs_byteenable_in[0]) |=>
        (s.en_cn == $past(avs_writedata_in[3]) && s.en_cmp == $past(avs_writedata_in[2])))
        else $error("change notify or comparator enable not at its bit");

    i2c_pos_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        (commit_wr && avs_address_in == `IEP_OFS_ENABLE && avs_byteenable_in[0]) |=>
        (s.en_mi2c == $past(avs_writedata_in[1]) && s.en_si2c == $past(avs_writedata_in[0])))
        else $error("i2c enable not at its bit");

    rsvd_zero_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        (avs_read_in && s.bus == iep_pkg::BUS_IDLE && avs_address_in == `IEP_OFS_ENABLE) |=>
        (avs_readdata_out[5] == 1'b0 && avs_readdata_out[31:7] == 25'h0))
        else $error("unimplemented enable bits read nonzero");

    rtc_prio_wr_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        (commit_wr && avs_address_in == `IEP_OFS_PRIO && avs_byteenable_in[1]) |=>
        s.rtc_prio == $past(avs_writedata_in[10:8]))
        else $error("rtc priority not taken from bits 10 to 8");

    rtc_off_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        (s.rtc_prio == 3'h0) |=> !(req_valid_out && req_source_out == `IEP_SRC_RTC_ID))
        else $error("rtc request passed with priority zero");

    // the winner is indexed by its own source number into last cycle's priorities
    win_prio_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        req_valid_out |-> (req_priority_out != 3'h0 &&
        req_priority_out == 3'($past(prio_vec) >> (3 * req_source_out)) &&
        (($past(elig) >> req_source_out) & 7'h01) != 7'h00))
        else $error("winning request priority mismatch");

    irq_level_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        (|(flags_in & ~s.flags_q & s.mask)) |=> irq_out)
        else $error("unmasked event did not raise the interrupt");
endmodule
`default_nettype wire

// file: shared/iep_defs.svh
// offsets, field positions, reset values and widths of the enable/priority slice
`ifndef IEP_DEFS_SVH
`define IEP_DEFS_SVH

`define IEP_ADDR_W 5
`define IEP_NSRC 7
`define IEP_PRIO_W 3

`define IEP_OFS_ENABLE 5'h00
`define IEP_OFS_PRIO 5'h04
`define IEP_OFS_STATUS 5'h08
`define IEP_OFS_MASK 5'h0C
`define IEP_OFS_SRCPRIO 5'h10
`define IEP_OFS_RTCCTL 5'h14

`define IEP_BIT_IC7 6
`define IEP_BIT_RSVD 5
`define IEP_BIT_INT1 4
`define IEP_BIT_CN 3
`define IEP_BIT_CMP 2
`define IEP_BIT_MI2C 1
`define IEP_BIT_SI2C 0
`define IEP_BIT_RTC_PRIO_LO 8
`define IEP_BIT_RTC_PRIO_HI 10
`define IEP_BIT_RTC_EN 0

`define IEP_SRC_SI2C 0
`define IEP_SRC_MI2C 1
`define IEP_SRC_CMP 2
`define IEP_SRC_CN 3
`define IEP_SRC_INT1 4
`define IEP_SRC_IC7 5
`define IEP_SRC_RTC 6
`define IEP_SRC_RTC_ID 3'h6

`define IEP_RST_EN 1'b0
`define IEP_RST_RTC_PRIO 3'h4
`define IEP_RST_SRC_PRIO 18'h24924
`define IEP_RST_STATUS 7'h00
`define IEP_RST_MASK 7'h00

`endif

// file: shared/iep_pkg.sv
// types shared by the enable/priority slice
`default_nettype none
package iep_pkg;
    typedef enum logic {BUS_IDLE, BUS_ACK} iep_bus_e;

    typedef struct packed {
        iep_bus_e bus;
        logic waitreq;
        logic [31:0] rdata;
        logic en_ic7;
        logic en_int1;
        logic en_cn;
        logic en_cmp;
        logic en_mi2c;
        logic en_si2c;
        logic rtc_en;
        logic [2:0] rtc_prio;
        logic [17:0] src_prio;
        logic [6:0] status;
        logic [6:0] mask;
        logic [6:0] flags_q;
        logic req_valid;
        logic [2:0] req_prio;
        logic [2:0] req_src;
        logic irq;
    } iep_state_s;
endpackage
`default_nettype wire

// file: tb/iep_core_model.sv
// core-side model that takes the presented interrupt request each cycle
`timescale 1ns/10ps
`default_nettype none

module iep_core_model (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic req_valid_in,
    input wire logic [2:0] req_priority_in,
    input wire logic [2:0] req_source_in,
    output logic [2:0] taken_priority_out,
    output logic [2:0] taken_source_out,
    output logic breach_out
);
    // sticky breach flag so a single bad cycle is not lost before the bench looks
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            taken_priority_out <= 3'h0;
            taken_source_out <= 3'h0;
            breach_out <= 1'b0;
        end else if (req_valid_in) begin
            taken_priority_out <= req_priority_in;
            taken_source_out <= req_source_in;
            if (req_priority_in == 3'h0) begin
                breach_out <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the enable/priority slice
`timescale 1ns/10ps
`default_nettype none
`include "iep_defs.svh"

module tb;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [4:0] addr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] be = 4'hF;
    logic [6:0] flags = 7'h00;
    logic [31:0] rdata;
    logic waitreq;
    logic req_valid;
    logic [2:0] req_prio;
    logic [2:0] req_src;
    logic irq;
    logic [2:0] core_prio;
    logic [2:0] core_src;
    logic core_bad;
    logic [31:0] got;
    int err_count = 0;
    int checks_done = 0;
    int bit_tab[6] = '{6, 4, 3, 2, 1, 0};
    logic [2:0] src_tab[6] = '{3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};

    always #5 mclk_in = ~mclk_in;

    iep_top u_iep_top (.mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
        .flags_in(flags), .req_valid_out(req_valid), .req_priority_out(req_prio),
        .req_source_out(req_src), .irq_out(irq));

    iep_core_model u_iep_core_model (.mclk_in(mclk_in), .rst_in(rst_in),
        .req_valid_in(req_valid), .req_priority_in(req_prio), .req_source_in(req_src),
        .taken_priority_out(core_prio), .taken_source_out(core_src), .breach_out(core_bad));

    task automatic close_out();
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: word %h expected %h", $time, g, e);
        end
    endtask

    task automatic check_bit(input logic g, input logic e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: bit %b expected %b", $time, g, e);
        end
    endtask

    // request held until the edge that samples waitrequest low, released at that edge
    task automatic bus_access(input logic is_wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_in);
        addr <= a;
        wdata <= d;
        rd <= ~is_wr;
        wr <= is_wr;
        do begin
            @(posedge mclk_in);
            n++;
        end while (waitreq !== 1'b0 && n < 20);
        if (waitreq !== 1'b0) begin
            err_count++;
            $display("Error at %0t: bus timeout", $time);
            close_out();
        end else begin
            got = rdata;
            rd <= 1'b0;
            wr <= 1'b0;
        end
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        bus_access(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
        bus_access(1'b0, a, 32'h0000_0000);
        check_word(got, e);
    endtask

    task automatic set_flags(input logic [6:0] f);
        @(posedge mclk_in);
        flags <= f;
    endtask

    // request outputs are one edge behind; two edges leave margin for register writes
    task automatic settle();
        repeat (2) @(posedge mclk_in);
        #1;
    endtask

    task automatic check_req(input logic v, input logic [2:0] p, input logic [2:0] s);
        check_bit(req_valid, v);
        check_word({29'h0, req_prio}, {29'h0, p});
        check_word({29'h0, req_src}, {29'h0, s});
    endtask

    initial begin
        repeat (6) @(posedge mclk_in);
        rst_in <= 1'b0;
        rd_chk(`IEP_OFS_ENABLE, 32'h0000_0000);
        rd_chk(`IEP_OFS_PRIO, 32'h0000_0400);
        wr_reg(`IEP_OFS_ENABLE, 32'hFFFF_FFFF);
        rd_chk(`IEP_OFS_ENABLE, 32'h0000_005F);
        // flags_in bit 4 stands for the external input already routed to a pin
        set_flags(7'h3F);
        settle();
        check_req(1'b1, 3'h4, 3'h0);
        for (int i = 0; i < 6; i++) begin
            wr_reg(`IEP_OFS_ENABLE, 32'h0000_0001 << bit_tab[i]);
            settle();
            check_req(1'b1, 3'h4, src_tab[i]);
        end
        wr_reg(`IEP_OFS_ENABLE, 32'h0000_0000);
        settle();
        check_req(1'b0, 3'h0, 3'h0);
        wr_reg(`IEP_OFS_SRCPRIO, 32'h0002_4124);
        wr_reg(`IEP_OFS_ENABLE, 32'h0000_0008);
        settle();
        check_req(1'b0, 3'h0, 3'h0);
        wr_reg(`IEP_OFS_SRCPRIO, 32'h0002_4924);
        set_flags(7'h48);
        wr_reg(`IEP_OFS_RTCCTL, 32'h0000_0001);
        for (int c = 0; c < 8; c++) begin
            wr_reg(`IEP_OFS_PRIO, {16'hFFFF, 5'h1F, c[2:0], 8'hFF});
            rd_chk(`IEP_OFS_PRIO, {21'h0, c[2:0], 8'h00});
            settle();
            if (c > 4) begin
                check_req(1'b1, c[2:0], 3'h6);
            end else begin
                check_req(1'b1, 3'h4, 3'h3);
            end
        end
        check_word({29'h0, core_src}, 32'h0000_0006);
        check_word({29'h0, core_prio}, 32'h0000_0007);
        wr_reg(`IEP_OFS_ENABLE, 32'h0000_0000);
        wr_reg(`IEP_OFS_PRIO, 32'h0000_0000);
        settle();
        check_req(1'b0, 3'h0, 3'h0);
        set_flags(7'h00);
        wr_reg(`IEP_OFS_STATUS, 32'h0000_007F);
        rd_chk(`IEP_OFS_STATUS, 32'h0000_0000);
        wr_reg(`IEP_OFS_MASK, 32'h0000_0004);
        set_flags(7'h04);
        settle();
        check_bit(irq, 1'b1);
        set_flags(7'h06);
        settle();
        rd_chk(`IEP_OFS_STATUS, 32'h0000_0006);
        wr_reg(`IEP_OFS_STATUS, 32'h0000_0004);
        settle();
        check_bit(irq, 1'b0);
        wr_reg(`IEP_OFS_MASK, 32'h0000_0002);
        rd_chk(`IEP_OFS_MASK, 32'h0000_0002);
        settle();
        check_bit(irq, 1'b1);
        wr_reg(`IEP_OFS_STATUS, 32'h0000_0002);
        settle();
        check_bit(irq, 1'b0);
        wr_reg(5'h18, 32'hFFFF_FFFF);
        rd_chk(5'h18, 32'h0000_0000);
        check_bit(core_bad, 1'b0);
        close_out();
    end
endmodule

`default_nettype wire
